// ### src/vct_pkg.sv
package vct_pkg;
  // Register byte offsets
  localparam logic [7:0] VCT_CTRL_OFS = 8'h00;
  localparam logic [7:0] VCT_STAT_OFS = 8'h04;
  localparam logic [7:0] VCT_IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] VCT_IRQ_MASK_OFS = 8'h0C;
  // Control field positions and reset value
  localparam int VCT_CTRL_MODE_LO_BIT = 0;
  localparam int VCT_CTRL_MODE_HI_BIT = 1;
  localparam int VCT_CTRL_DFR_BIT = 2;
  localparam logic [2:0] VCT_CTRL_RST = 3'h0;
  // Status field positions
  localparam int VCT_STAT_FLAG_BIT = 0;
  localparam int VCT_STAT_STD625_BIT = 1;
  localparam int VCT_STAT_ENGAGED_BIT = 2;
  localparam int VCT_STAT_COIN_LSB = 4;
  localparam int VCT_STAT_LEN_LSB = 16;
  // Interrupt bit positions
  localparam int VCT_IRQ_ENGAGE_BIT = 0;
  localparam int VCT_IRQ_DROP_BIT = 1;
  localparam int VCT_IRQ_STD_BIT = 2;
  localparam int VCT_IRQ_W = 3;
  // Line counts, normal field rate
  localparam logic [9:0] VCT_LINES_625 = 10'd625;
  localparam logic [9:0] VCT_LINES_525 = 10'd525;
  localparam logic [9:0] VCT_STOP_LOW = 10'd512;
  localparam logic [9:0] VCT_STOP_HIGH = 10'd672;
  localparam logic [9:0] VCT_STD_SPLIT = 10'd576;
  // Coincidence counter
  localparam logic [3:0] VCT_COIN_MAX = 4'hF;
  localparam logic [3:0] VCT_COIN_ENGAGE = 4'h8;
  // Vertical sync separator threshold: sync high time only broad pulses reach
  localparam int VCT_CLK_MHZ = 125;
  localparam int VCT_VSEP_NS = 16000;
  localparam int VCT_VSEP_CYC = (VCT_VSEP_NS * VCT_CLK_MHZ + 999) / 1000;
  localparam int VCT_VSEP_W = 12;
  localparam logic [VCT_VSEP_W-1:0] VCT_VSEP_THR = VCT_VSEP_W'(VCT_VSEP_CYC);
  localparam logic [VCT_VSEP_W-1:0] VCT_VSEP_MAX = '1;
  // Operating modes as coded by the two mode select bits
  typedef enum logic [1:0] {
    VCT_MODE_INJECT = 2'h0,
    VCT_MODE_AUTO = 2'h1,
    VCT_MODE_F525 = 2'h2,
    VCT_MODE_F625 = 2'h3
  } vct_mode_t;
endpackage : vct_pkg

// ### src/vct_timebase.sv
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
module vct_timebase (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_line_pulse,
  input wire logic i_comp_sync,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic o_irq,
  output logic o_field_start,
  output logic [9:0] o_line_count,
  output logic o_countdown_flag,
  output logic o_std_625
);
  import vct_pkg::*;

  // Pin synchronisers and sync separator state
  logic [2:0] line_sync_q;
  logic [1:0] csync_sync_q;
  logic line_tick;
  logic [VCT_VSEP_W-1:0] vsep_q;
  logic vsync_evt;
  logic vs_pend_q;
  // Host control word and its decoded mode
  logic [2:0] ctrl_q;
  vct_mode_t mode;
  logic dfr;
  // Field timing and coincidence state
  logic [9:0] line_q;
  logic [9:0] len_q;
  logic [3:0] coin_q;
  logic engaged_q;
  logic std625_q;
  // Interrupt and read-back registers
  logic [VCT_IRQ_W-1:0] irq_stat_q;
  logic [VCT_IRQ_W-1:0] irq_mask_q;
  logic [31:0] rdata_q;
  logic field_start_q;
  // Decisions taken on the current line tick
  // All but stat_rd settle from registers within the same cycle
  logic [9:0] lines_next;
  logic [9:0] expect_len;
  logic [9:0] stop_low;
  logic [9:0] stop_high;
  logic [9:0] std_split;
  logic [9:0] forced_len;
  logic forced;
  logic countdown;
  logic restart;
  logic judge;
  logic coin_hit;
  logic coin_miss;
  logic [3:0] coin_d;
  logic engaged_d;
  logic std_d;
  logic [VCT_IRQ_W-1:0] irq_evt;
  logic stat_rd;

  // Mode bits decoded straight from the control word
  assign mode = vct_mode_t'(ctrl_q[VCT_CTRL_MODE_HI_BIT:VCT_CTRL_MODE_LO_BIT]);
  assign dfr = ctrl_q[VCT_CTRL_DFR_BIT];

  // Pins from the line PLL and sync slicer pass two flops first
  // The third line flop only feeds the edge detector below
  // Clearing to zero matches the idle low pins, so no false edge follows
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      line_sync_q <= 3'h0;
      csync_sync_q <= 2'h0;
    end else begin
      line_sync_q <= {line_sync_q[1:0], i_line_pulse};
      csync_sync_q <= {csync_sync_q[0], i_comp_sync};
    end
  end
  // One tick per rising edge of the line pulse
  assign line_tick = line_sync_q[1] & ~line_sync_q[2];

  // Sync separator counter; only broad pulses keep sync high long enough
  // Saturating at both ends stops wrap-around on long sync or silence
  // Short line and equalising pulses never climb near the threshold
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      vsep_q <= '0;
    end else if (csync_sync_q[1]) begin
      if (vsep_q != VCT_VSEP_MAX) vsep_q <= vsep_q + 1'b1;
    end else if (vsep_q != '0) begin
      vsep_q <= vsep_q - 1'b1;
    end
  end
  // Upward crossing of the threshold is one vertical sync event
  // Matching one below the threshold gives a single event per climb
  assign vsync_evt = csync_sync_q[1] &&
                     vsep_q == VCT_VSEP_THR - 1'b1;

  // Vertical sync is held until the next line tick judges it
  // A sync landing on a tick is judged at the following tick
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      vs_pend_q <= 1'b0;
    end else if (vsync_evt) begin
      vs_pend_q <= 1'b1;
    end else if (line_tick) begin
      vs_pend_q <= 1'b0;
    end
  end

  // Limits scale with double field rate mode; 525 and 625 alike
  // The shift drops the half line of 625 and 525 in double rate
  // Halving keeps both end stops and the split in proportion
  always_comb begin
    stop_low = dfr ? (VCT_STOP_LOW >> 1) : VCT_STOP_LOW;
    stop_high = dfr ? (VCT_STOP_HIGH >> 1) : VCT_STOP_HIGH;
    std_split = dfr ? (VCT_STD_SPLIT >> 1) : VCT_STD_SPLIT;
    expect_len = std625_q ? VCT_LINES_625 : VCT_LINES_525;
    if (dfr) expect_len = expect_len >> 1;
    forced_len = (mode == VCT_MODE_F625) ? VCT_LINES_625 : VCT_LINES_525;
    if (dfr) forced_len = forced_len >> 1;
  end

  // Field restart decision, evaluated on each line tick
  // Forced modes never look at the pending sync
  // A hit and a miss never come together on one tick
  always_comb begin
    lines_next = line_q + 1'b1;
    forced = (mode == VCT_MODE_F525) || (mode == VCT_MODE_F625);
    countdown = (mode == VCT_MODE_AUTO) && engaged_q;
    restart = 1'b0;
    judge = 1'b0;
    coin_hit = 1'b0;
    coin_miss = 1'b0;
    if (line_tick) begin
      if (forced) begin
        restart = (lines_next >= forced_len);
      end else if (countdown) begin
        // Countdown restarts on the expected count and grades the sync
        // A sync away from the expected line counts as a miss
        restart = (lines_next >= expect_len);
        coin_hit = restart && vs_pend_q;
        coin_miss = (restart && !vs_pend_q) ||
                    (!restart && vs_pend_q);
      end else begin
        // Injection lock follows the first sync inside the window
        // A sync below the floor is dropped with the pending flag
        restart = (vs_pend_q && lines_next >= stop_low) ||
                  (lines_next >= stop_high);
        judge = restart;
        coin_hit = judge && vs_pend_q && lines_next == expect_len;
        coin_miss = judge && !coin_hit;
      end
    end
  end

  // Line counter and field length of the last field
  // Length holds the restart line, the tick count of the field just ended
  // Field start is a registered copy of the restart decision
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      line_q <= 10'h000;
      len_q <= 10'h000;
      field_start_q <= 1'b0;
    end else begin
      field_start_q <= restart;
      if (restart) begin
        line_q <= 10'h000;
        len_q <= lines_next;
      end else if (line_tick) begin
        line_q <= lines_next;
      end
    end
  end

  // Saturating coincidence counter and countdown engagement
  // Engagement needs auto mode as well as eight counted hits
  // Leaving auto drops engagement at once, the host's fast path
  always_comb begin
    coin_d = coin_q;
    if (coin_hit && coin_q != VCT_COIN_MAX) coin_d = coin_q + 1'b1;
    if (coin_miss && coin_q != 4'h0) coin_d = coin_q - 1'b1;
    engaged_d = engaged_q;
    if (mode != VCT_MODE_AUTO) begin
      engaged_d = 1'b0;
    end else if (coin_d >= VCT_COIN_ENGAGE) begin
      engaged_d = 1'b1;
    end else if (coin_d == 4'h0) begin
      engaged_d = 1'b0;
    end
    // Standard class from every injection-lock field, end stop included, and countdown fields
    // Forced fields say nothing about the received standard
    std_d = std625_q;
    if (judge || (countdown && restart)) begin
      std_d = (lines_next > std_split);
    end
  end

  // Coincidence state; the standard class starts out at 625 lines
  // Every step of the counter is applied here, hit or miss
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      coin_q <= 4'h0;
      engaged_q <= 1'b0;
      std625_q <= 1'b1;
    end else begin
      coin_q <= coin_d;
      engaged_q <= engaged_d;
      std625_q <= std_d;
    end
  end

  // Control register; field decisions take a mode change on the next line tick
  // The field in progress keeps running until a tick decides
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      ctrl_q <= VCT_CTRL_RST;
    end else if (i_wr && i_addr == VCT_CTRL_OFS) begin
      ctrl_q <= i_wdata[2:0];
    end
  end

  // Interrupt events: engage, drop back, standard change
  // Each event is a one-cycle edge of engagement or standard class
  assign irq_evt[VCT_IRQ_ENGAGE_BIT] = engaged_d & ~engaged_q;
  assign irq_evt[VCT_IRQ_DROP_BIT] = engaged_q & ~engaged_d;
  assign irq_evt[VCT_IRQ_STD_BIT] = std_d ^ std625_q;
  assign stat_rd = i_rd && i_addr == VCT_IRQ_STAT_OFS;

  // Read clears, but an event in the same cycle survives
  // Set wins, so no event is lost to a read racing it
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (stat_rd ? '0 : irq_stat_q) | irq_evt;
    end
  end

  // A one in the mask lets the matching status bit raise the interrupt
  // Writes to the mask do not touch pending status bits
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      irq_mask_q <= '0;
    end else if (i_wr && i_addr == VCT_IRQ_MASK_OFS) begin
      irq_mask_q <= i_wdata[VCT_IRQ_W-1:0];
    end
  end

  // Read data stand one cycle after the strobe; unmapped reads give zero
  // Zero outside the read cycle keeps the data lines quiet when idle
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      rdata_q <= 32'h0000_0000;
    end else if (i_rd) begin
      rdata_q <= 32'h0000_0000;
      unique case (i_addr)
        VCT_CTRL_OFS: rdata_q[2:0] <= ctrl_q;
        // Status packs flag, class, engagement, count and last length
        VCT_STAT_OFS: begin
          rdata_q[VCT_STAT_FLAG_BIT] <= coin_q[3];
          rdata_q[VCT_STAT_STD625_BIT] <= std625_q;
          rdata_q[VCT_STAT_ENGAGED_BIT] <= engaged_q;
          rdata_q[VCT_STAT_COIN_LSB +: 4] <= coin_q;
          rdata_q[VCT_STAT_LEN_LSB +: 10] <= len_q;
        end
        VCT_IRQ_STAT_OFS: rdata_q[VCT_IRQ_W-1:0] <= irq_stat_q;
        VCT_IRQ_MASK_OFS: rdata_q[VCT_IRQ_W-1:0] <= irq_mask_q;
        default: rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  // All outputs but the interrupt come straight from registers
  // The flag is the counter top bit, not the engaged state
  // Interrupt is a level, high while any enabled event is pending
  assign o_rdata = rdata_q;
  assign o_irq = |(irq_stat_q & irq_mask_q);
  assign o_field_start = field_start_q;
  assign o_line_count = line_q;
  assign o_countdown_flag = coin_q[3];
  assign o_std_625 = std625_q;
endmodule : vct_timebase
`default_nettype wire

// ### verif/vct_timebase_properties.sv
`timescale 1ns/1ps
`default_nettype none
module vct_timebase_properties
  import vct_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic o_field_start,
  input wire logic [9:0] o_line_count,
  input wire logic o_countdown_flag
);
  logic [2:0] ctrl_q;
  logic fresh_q;
  logic [9:0] floor_w, top_w, last_w;
  // Limits follow the mode word the host last wrote
  assign floor_w = (VCT_STOP_LOW >> ctrl_q[2]) - 10'h1;
  assign top_w = (VCT_STOP_HIGH >> ctrl_q[2]) - 10'h1;
  assign last_w = ((ctrl_q[0] ? VCT_LINES_625 : VCT_LINES_525)
                   >> ctrl_q[2]) - 10'h1;
  // Shadow of the control word, seen from the bus
  always_ff @(posedge i_clock) begin
    if (i_reset) ctrl_q <= VCT_CTRL_RST;
    else if (i_wr && i_addr == VCT_CTRL_OFS) ctrl_q <= i_wdata[2:0];
  end
  // A field cut short by a mode change is judged against the floor only, not the ceiling or forced length
  always_ff @(posedge i_clock) begin
    if (i_reset || (i_wr && i_addr == VCT_CTRL_OFS)) fresh_q <= 1'b1;
    else if (o_field_start) fresh_q <= 1'b0;
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);
  a_start_floor: assert property (
    o_field_start |-> $past(o_line_count) >= floor_w)
    else $error("field restarted below the window floor");
  a_line_ceiling: assert property (
    !fresh_q |-> o_line_count <= top_w)
    else $error("line count passed the upper end stop");
  a_line_step: assert property (
    $changed(o_line_count) |-> o_line_count == 10'h0
      || o_line_count == $past(o_line_count) + 10'h1)
    else $error("line count jumped");
  a_start_zero: assert property (
    o_field_start |-> o_line_count == 10'h0)
    else $error("field start without line count cleared");
  a_forced_len: assert property (
    o_field_start && ctrl_q[1] && !fresh_q |-> $past(o_line_count) == last_w)
    else $error("forced field length wrong");
  a_rdata_idle: assert property (
    !$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside its cycle");
  a_unmapped_zero: assert property (
    $past(i_rd) && ($past(i_addr) & 8'hF3) != 8'h0 |-> o_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_flag_msb: assert property (
    $past(i_rd) && $past(i_addr) == VCT_STAT_OFS
      |-> o_rdata[0] == o_rdata[7] && (!o_rdata[2] || o_rdata[7:4] != 4'h0))
    else $error("flag differs from counter top bit");
  a_engage_mode: assert property (
    $past(i_rd) && $past(i_addr) == VCT_STAT_OFS
      && $past(ctrl_q[1:0], 2) != 2'h1 |-> !o_rdata[2])
    else $error("countdown engaged outside auto mode");
  c_engaged: cover property ($rose(o_countdown_flag));
  c_forced: cover property (o_field_start && ctrl_q[1] && !fresh_q);
  c_double: cover property (o_field_start && ctrl_q[2]);
endmodule : vct_timebase_properties
bind vct_timebase vct_timebase_properties i_chk (.i_clock, .i_reset,
  .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_field_start,
  .o_line_count, .o_countdown_flag);
`default_nettype wire

// ### verif/vct_video_src.sv
`timescale 1ns/1ps
`default_nettype none
// Video source: one line every 8 clocks, broad pulses once a field
module vct_video_src (
  input wire logic i_clock,
  input wire logic i_run,
  input wire logic i_sync_on,
  input wire logic [9:0] i_lines,
  output logic o_line_pulse,
  output logic o_comp_sync
);
  logic [12:0] pos_q;
  logic [12:0] end_w;
  assign end_w = {i_lines, 3'h0};
  // Sync rises late so the separator trips inside the field's last line
  always_ff @(posedge i_clock) begin
    pos_q <= (!i_run || pos_q == end_w - 13'h1) ? 13'h0 : pos_q + 13'h1;
    o_line_pulse <= i_run && pos_q[2:0] < 3'h4;
    o_comp_sync <= i_run && i_sync_on
      && (pos_q >= end_w - 13'h7D4 || pos_q < 13'h30);
  end
endmodule : vct_video_src
`default_nettype wire

// ### verif/vct_timebase_tb.sv
`timescale 1ns/1ps
`default_nettype none
module vct_timebase_tb;
  import vct_pkg::*;
  logic i_clock, i_reset, i_wr, i_rd, run, sync_on, line_w, sync_w;
  logic o_irq, o_field_start, o_countdown_flag, o_std_625;
  logic [7:0] i_addr;
  logic [31:0] i_wdata, o_rdata, rd_v;
  logic [9:0] o_line_count, n;
  logic [2:0] m;
  logic [2:0] rows [6] = '{3'h0, 3'h2, 3'h3, 3'h6, 3'h7, 3'h4};
  int bad_count, checked, cyc;
  vct_timebase i_dut (.i_clock, .i_reset, .i_line_pulse(line_w),
    .i_comp_sync(sync_w), .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .o_irq, .o_field_start, .o_line_count, .o_countdown_flag, .o_std_625);
  vct_video_src i_src (.i_clock, .i_run(run), .i_sync_on(sync_on),
    .i_lines(VCT_LINES_525), .o_line_pulse(line_w), .o_comp_sync(sync_w));
  task automatic chk(input string name, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1;
    rd_v = o_rdata;
  endtask : rd
  // Clocks from the call to the next field start, bounded at 6000
  task automatic wait_start();
    cyc = 0;
    do begin
      @(posedge i_clock);
      #1;
      cyc++;
    end while (o_field_start !== 1'b1 && cyc < 6000);
  endtask : wait_start
  task automatic results();
    $display("checked %0d bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end
  // Watchdog sized a little above the longest expected run
  initial begin
    #800000;
    bad_count++;
    results();
  end
  initial begin
    {i_wr, i_rd, run, i_addr, i_wdata} = '0;
    sync_on = 1'b1;
    i_reset = 1'b1;
    repeat (8) @(posedge i_clock);
    i_reset <= 1'b0;
    rd(VCT_STAT_OFS);
    chk("status", rd_v, 32'h2);
    chk("std", o_std_625, 1'b1);
    rd(VCT_IRQ_MASK_OFS);
    chk("mask", rd_v, 32'h0);
    rd(8'h10);
    chk("unmapped", rd_v, 32'h0);
    $display("reset test done");
    wr(VCT_IRQ_MASK_OFS, 32'h7);
    wr(VCT_CTRL_OFS, 32'h1);
    run <= 1'b1;
    // The first field after reset is a miss against the 625-line reset class, so nine fields engage
    for (int i = 1; i <= 9; i++) begin
      wait_start();
      #17;
      chk("flag", o_countdown_flag, i >= 9);
    end
    chk("std", o_std_625, 1'b0);
    chk("irq", o_irq, 1'b1);
    rd(VCT_STAT_OFS);
    chk("status", rd_v, 32'h020D_0085);
    rd(VCT_IRQ_STAT_OFS);
    chk("irq_stat", rd_v, 32'h5);
    #16;
    chk("irq", o_irq, 1'b0);
    wr(VCT_CTRL_OFS, 32'h0);
    rd(VCT_STAT_OFS);
    chk("engaged", rd_v[2], 1'b0);
    $display("engage test done");
    // Each mode row: sync only where the mode must ignore it
    for (int k = 0; k < 6; k++) begin
      m = rows[k];
      sync_on <= m[1];
      n = m[1] ? (m[0] ? VCT_LINES_625 : VCT_LINES_525) : VCT_STOP_HIGH;
      n = n >> m[2];
      wr(VCT_CTRL_OFS, {29'h0, m});
      wait_start();
      wait_start();
      chk("period", cyc, {n, 3'h0});
      if (m == 3'h0) begin
        rd(VCT_STAT_OFS);
        chk("status", rd_v, 32'h02A0_0062);
        rd(VCT_IRQ_STAT_OFS);
        chk("irq_stat", rd_v, 32'h6);
      end
    end
    $display("mode test done");
    results();
  end
endmodule : vct_timebase_tb
`default_nettype wire
